/* File: hw/scprb_device.sv */
`timescale 1ns/1ns
`include "scprb_consts.svh"
// Overview of operation
// [R1] Shift only while window low
// [R2] Sample input on rising serial clock
// [R3] Write register on every 24th edge; in readback mode the code writes only the control register 0x00
// [R4] Drop trailing partial word silently
// [R5] Bit counter restarts at window fall
// [R6] Word is 8-bit address, 16-bit data
// [R7] Most significant bit first
// [R8] Host writes zeros to unused bits
// [R9] Works from 20 MHz to hertz
// [R10] Host keeps clock period, phase minimums
// [R11] Host keeps 8 ns window margins
// [R12] Readback mode shifts addressed register out
// [R13] Output changes after falling serial edge
// [R14] Readback bit stays writable; clear restores
// [R15] Output high impedance unless readback set
// [R16] Hardware reset pulse initializes registers
// [R17] Software reset restores defaults, self-clears
// [R18] Reset bit 0, readback bit 1
// [R19] Plain registers reset to zero
// [R20] Demodulator registers reset to ones
// [R21] Clearing demod enable resets demod registers
module scprb_device (
    input wire logic mclk,
    input wire logic rst_n,
    scprb_if.device link,
    output logic [7:0] last_addr,
    output logic [15:0] last_data,
    output logic write_pulse,
    output logic readback_mode
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] win_sync;
    logic [1:0] clk_sync;
    logic [1:0] din_sync;
    logic [1:0] rst_sync;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            win_sync <= 2'h3;
        end else begin
            win_sync <= {win_sync[0], link.serial_window_n}; // [R1]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_sync <= 2'h0;
        end else begin
            clk_sync <= {clk_sync[0], link.sclk}; // [R9]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            din_sync <= 2'h0;
        end else begin
            din_sync <= {din_sync[0], link.serial_in_line}; // [R2]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], link.hw_reset}; // [R16]
        end
    end

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    logic clk_prev;
    logic win_prev;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_prev <= 1'b0;
            win_prev <= 1'b1;
        end else begin
            clk_prev <= clk_sync[1];
            win_prev <= win_sync[1];
        end
    end
    wire win_low = ~win_sync[1];
    wire rise = win_low & clk_sync[1] & ~clk_prev; // [R1] [R2] [R9]
    wire fall = win_low & ~clk_sync[1] & clk_prev; // [R13]
    wire win_fall = win_prev & ~win_sync[1]; // [R5]
    wire hw_rst = rst_sync[1]; // [R16]

    // ----------------------------------------
    // Bit counter and shift register
    // ----------------------------------------
    logic [4:0] bit_cnt;
    logic [22:0] shift;
    wire last_bit = (bit_cnt == 5'(`SCPRB_WORD_BITS - 1));
    wire cnt_clear = !rst_n || win_fall || win_sync[1]; // [R4] [R5]
    wire [4:0] next_bit_cnt = last_bit ? 5'h00 : bit_cnt + 5'h01;
    wire [23:0] word = {shift, din_sync[1]}; // [R7]
    always_ff @(posedge mclk) begin
        if (cnt_clear) begin
            bit_cnt <= 5'h00; // [R4] [R5]
            shift <= 23'h000000;
        end else if (rise) begin
            bit_cnt <= next_bit_cnt;
            shift <= word[22:0];
        end
    end

    // ----------------------------------------
    // Word decode
    // ----------------------------------------
    logic [15:0] regs [0:255];
    logic readback;
    wire [7:0] w_addr = word[`SCPRB_ADDR_MSB:`SCPRB_ADDR_LSB]; // [R6]
    wire [15:0] w_data = word[`SCPRB_DATA_MSB:0];
    wire word_done = rise & last_bit; // [R3]
    wire addr_done = rise & (bit_cnt == 5'(`SCPRB_WORD_BITS - `SCPRB_ADDR_LSB - 1)); // [R12]
    wire addr_is_ctrl = (w_addr == `SCPRB_REG_CTRL);
    wire addr_is_demod = (w_addr == `SCPRB_REG_DEMOD_CTRL);
    wire write_open = ~readback | addr_is_ctrl; // [R14]
    wire do_write = word_done & write_open; // [R3]
    wire swrst_req = w_data[`SCPRB_CTRL_SWRST_BIT]; // [R18]
    wire sw_reset = do_write & addr_is_ctrl & swrst_req; // [R17]
    wire all_reset = !rst_n | hw_rst | sw_reset; // [R16] [R17]

    // ----------------------------------------
    // Register array
    // ----------------------------------------
    wire demod_en_old = regs[`SCPRB_REG_DEMOD_CTRL][`SCPRB_DEMOD_EN_BIT];
    wire demod_en_new = w_data[`SCPRB_DEMOD_EN_BIT];
    wire demod_clear = do_write & addr_is_demod & demod_en_old & ~demod_en_new; // [R21]
    assign readback = regs[`SCPRB_REG_CTRL][`SCPRB_CTRL_READBACK_BIT]; // [R18]
    genvar gi;
    generate
        for (gi = 0; gi < 256; gi++) begin : g_reg
            localparam bit IN_DEMOD = (gi >= `SCPRB_DEMOD_FIRST);
            localparam logic [15:0] DEF = IN_DEMOD ? `SCPRB_DEMOD_DEFAULT : `SCPRB_PLAIN_DEFAULT; // [R19] [R20]
            wire hit = do_write & (w_addr == 8'(gi));
            always_ff @(posedge mclk) begin
                if (all_reset) begin
                    regs[gi] <= DEF; // [R16] [R17]
                end else if (demod_clear && IN_DEMOD) begin
                    regs[gi] <= DEF; // [R21]
                end else if (hit) begin
                    regs[gi] <= w_data;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Readback shifter
    // ----------------------------------------
    logic [15:0] out_shift;
    logic load_pend;
    logic out_bit;
    wire [7:0] rd_addr = word[7:0];
    wire rd_load = readback & addr_done; // [R12]
    wire rd_step = fall & load_pend; // [R13]
    wire [15:0] next_out_shift = rd_load ? regs[rd_addr] : {out_shift[14:0], 1'b0};
    always_ff @(posedge mclk) begin
        if (all_reset) begin
            out_shift <= 16'h0000;
        end else if (rd_load || rd_step) begin
            out_shift <= next_out_shift;
        end
    end

    always_ff @(posedge mclk) begin
        if (all_reset || win_fall) begin
            load_pend <= 1'b0;
        end else if (rd_load) begin
            load_pend <= 1'b1;
        end
    end

    // ----------------------------------------
    // Output driver
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (all_reset) begin
            out_bit <= 1'b0;
        end else if (rd_step) begin
            out_bit <= out_shift[15]; // [R13]
        end
    end
    assign link.serial_out_line_o = out_bit;
    assign link.serial_out_line_oe_n = ~readback; // [R15]

    // ----------------------------------------
    // User-side status
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            write_pulse <= 1'b0;
        end else begin
            write_pulse <= do_write; // [R3]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_addr <= 8'h00;
            last_data <= 16'h0000;
        end else if (do_write) begin
            last_addr <= w_addr; // [R6]
            last_data <= w_data;
        end
    end
    assign readback_mode = readback;
endmodule : scprb_device

/* File: hw/scprb_consts.svh */
`ifndef SCPRB_CONSTS_SVH
`define SCPRB_CONSTS_SVH
`define SCPRB_WORD_BITS 24
`define SCPRB_ADDR_MSB 23
`define SCPRB_ADDR_LSB 16
`define SCPRB_DATA_MSB 15
`define SCPRB_REG_CTRL 8'h00
`define SCPRB_REG_DEMOD_CTRL 8'h16
`define SCPRB_CTRL_SWRST_BIT 0
`define SCPRB_CTRL_READBACK_BIT 1
`define SCPRB_DEMOD_EN_BIT 0
`define SCPRB_DEMOD_FIRST 8'h80
`define SCPRB_DEMOD_DEFAULT 16'hFFFF
`define SCPRB_PLAIN_DEFAULT 16'h0000
`define SCPRB_MCLK_NS 20
`define SCPRB_SCLK_PERIOD_NS 160
`define SCPRB_SCLK_HALF_CYC ((`SCPRB_SCLK_PERIOD_NS / 2) / `SCPRB_MCLK_NS)
`endif

/* File: hw/scprb_pkg.sv */
package scprb_pkg;
    typedef enum logic [2:0] {
        SCPRB_IDLE = 3'b001,
        SCPRB_LOW = 3'b010,
        SCPRB_HIGH = 3'b100
    } scprb_host_state_t;
endpackage : scprb_pkg

/* File: hw/scprb_if.sv */
`timescale 1ns/1ns
interface scprb_if;
    logic serial_window_n;
    logic sclk;
    logic serial_in_line;
    logic hw_reset;
    logic serial_out_line_o;
    logic serial_out_line_oe_n;
    modport device (
        input serial_window_n, sclk, serial_in_line, hw_reset,
        output serial_out_line_o, serial_out_line_oe_n
    );
    modport host (
        output serial_window_n, sclk, serial_in_line, hw_reset,
        input serial_out_line_o, serial_out_line_oe_n
    );
endinterface : scprb_if

/* File: hw/scprb_host.sv */
`timescale 1ns/1ns
`include "scprb_consts.svh"
module scprb_host (
    input wire logic mclk,
    input wire logic rst_n,
    scprb_if.host link,
    input wire logic start,
    input wire logic [7:0] addr,
    input wire logic [15:0] data,
    input wire logic hw_reset_req,
    output logic busy,
    output logic done,
    output logic [15:0] read_data
);
    // ----------------------------------------
    // Clock divider and frame sequencer
    // ----------------------------------------
    scprb_pkg::scprb_host_state_t state;
    logic [4:0] bits_left;
    logic [7:0] div;
    logic [23:0] tx;
    logic [1:0] so_sync;
    logic [1:0] oe_sync;
    logic sclk;
    wire tick = (div == 8'(`SCPRB_SCLK_HALF_CYC - 1)); // [R10]
    wire so_level = oe_sync[1] ? ~so_sync[1] : so_sync[1]; // [R15]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            so_sync <= 2'h0;
            oe_sync <= 2'h3;
        end else begin
            so_sync <= {so_sync[0], link.serial_out_line_o};
            oe_sync <= {oe_sync[0], link.serial_out_line_oe_n};
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= scprb_pkg::SCPRB_IDLE;
            bits_left <= 5'h00;
            div <= 8'h00;
            tx <= 24'h000000;
            sclk <= 1'b0;
            done <= 1'b0;
            read_data <= 16'h0000;
        end else begin
            done <= 1'b0;
            div <= (state == scprb_pkg::SCPRB_IDLE || tick) ? 8'h00 : div + 8'h01;
            case (state)
                scprb_pkg::SCPRB_IDLE: begin
                    if (start) begin
                        tx <= {addr, data}; // [R6] [R7] [R8]
                        bits_left <= 5'(`SCPRB_WORD_BITS);
                        state <= scprb_pkg::SCPRB_LOW; // [R11]
                    end
                end
                scprb_pkg::SCPRB_LOW: begin
                    if (tick) begin
                        sclk <= 1'b1;
                        state <= scprb_pkg::SCPRB_HIGH;
                    end
                end
                scprb_pkg::SCPRB_HIGH: begin
                    if (tick) begin
                        sclk <= 1'b0;
                        read_data <= {read_data[14:0], so_level}; // [R13]
                        tx <= {tx[22:0], 1'b0};
                        bits_left <= bits_left - 5'h01;
                        if (bits_left == 5'h01) begin
                            state <= scprb_pkg::SCPRB_IDLE; // [R11]
                            done <= 1'b1;
                        end else begin
                            state <= scprb_pkg::SCPRB_LOW;
                        end
                    end
                end
                default: state <= scprb_pkg::SCPRB_IDLE;
            endcase
        end
    end
    assign busy = (state != scprb_pkg::SCPRB_IDLE);
    assign link.serial_window_n = ~busy;
    assign link.sclk = sclk;
    assign link.serial_in_line = tx[23];
    assign link.hw_reset = hw_reset_req; // [R16]
endmodule : scprb_host

/* File: tb/scprb_checker.sv */
`timescale 1ns/1ns
module scprb_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_window_n,
    input wire logic sclk,
    input wire logic hw_reset,
    input wire logic serial_out_line_o,
    input wire logic serial_out_line_oe_n,
    input wire logic write_pulse,
    input wire logic readback_mode
);
    logic sclk_q;
    logic [4:0] rises;
    logic [3:0] since;
    wire rise = sclk & ~sclk_q;
    wire last_rise = rise & (rises == 5'h17);
    wire aging = (since != 4'h0) && (since != 4'hF);
    always_ff @(posedge mclk) begin
        sclk_q <= sclk;
        rises <= serial_window_n ? 5'h00 : rises + {4'h0, rise};
        since <= !rst_n ? 4'h0 : last_rise ? 4'h1 : since + {3'h0, aging};
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    idle_clock_a:
        assert property (serial_window_n && $past(serial_window_n) |-> !sclk) else $error("clock outside window");
    high_phase_a:
        assert property ($rose(sclk) |-> sclk[*4]) else $error("short clock high");
    low_phase_a:
        assert property ($fell(sclk) |-> !sclk[*4]) else $error("short clock low");
    window_edge_a:
        assert property ($fell(serial_window_n) || $rose(serial_window_n) |-> !$rose(sclk)) else $error("edge margin");
    word_count_a:
        assert property ($rose(serial_window_n) |-> rises == 5'h18) else $error("rises per window");
    write_late_a:
        assert property (write_pulse |-> since >= 4'h1 && since <= 4'h7) else $error("stray write");
    write_due_a:
        assert property (last_rise && !readback_mode |-> ##[1:8] write_pulse) else $error("missing write");
    out_hiz_a:
        assert property (!readback_mode && !$past(readback_mode) |-> serial_out_line_oe_n) else $error("output driven");
    out_fall_a:
        assert property (!serial_out_line_oe_n && !$past(serial_out_line_oe_n) && $changed(serial_out_line_o) |-> !sclk)
        else $error("output moved on high clock");
    hw_clear_a:
        assert property ($rose(hw_reset) |-> ##[1:6] !readback_mode) else $error("mode kept over reset");
endmodule : scprb_checker

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] data = 16'h0000;
    logic hw_reset_req = 1'b0;
    logic busy, done, write_pulse, readback_mode;
    logic [7:0] last_addr;
    logic [15:0] last_data, read_data;
    int errors = 0;
    int num_checks = 0;
    int pulses = 0;
    int p;
    always #10 mclk = ~mclk;
    always @(posedge mclk) pulses <= pulses + int'(write_pulse === 1'b1);
    scprb_if i_scprb_if ();
    scprb_host i_scprb_host (.mclk(mclk), .rst_n(rst_n), .link(i_scprb_if.host), .start(start), .addr(addr),
        .data(data), .hw_reset_req(hw_reset_req), .busy(busy), .done(done), .read_data(read_data));
    scprb_device i_scprb_device (.mclk(mclk), .rst_n(rst_n), .link(i_scprb_if.device), .last_addr(last_addr),
        .last_data(last_data), .write_pulse(write_pulse), .readback_mode(readback_mode));
    scprb_checker i_scprb_checker (.mclk(mclk), .rst_n(rst_n), .serial_window_n(i_scprb_if.serial_window_n),
        .sclk(i_scprb_if.sclk), .hw_reset(i_scprb_if.hw_reset), .serial_out_line_o(i_scprb_if.serial_out_line_o),
        .serial_out_line_oe_n(i_scprb_if.serial_out_line_oe_n), .write_pulse(write_pulse),
        .readback_mode(readback_mode));
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task automatic send(input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        start <= 1'b1;
        addr <= a;
        data <= d;
        @(posedge mclk);
        start <= 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        if (n == 400) begin
            errors++;
            close_out();
        end else begin
            repeat (8) @(negedge mclk);
            check("busy", 16'h0000, {15'h0, busy});
            check("done", 16'h0000, {15'h0, done});
        end
    endtask : send
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        p = pulses;
        send(a, d);
        check("pulses", 16'(p + 1), 16'(pulses));
        check("addr", {8'h00, a}, {8'h00, last_addr});
        check("data", d, last_data);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        send(a, 16'h0000);
        check("read", exp, read_data);
    endtask : rd
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check("mode", 16'h0000, {15'h0, readback_mode});
        check("oe_n", 16'h0001, {15'h0, i_scprb_if.serial_out_line_oe_n});
        wr(8'h01, 16'hA5C3);
        wr(8'h80, 16'h1234);
        wr(8'h16, 16'h0001);
        wr(8'h00, 16'h0002);
        $display("test write done");
        p = pulses;
        rd(8'h01, 16'hA5C3);
        rd(8'h80, 16'h1234);
        check("refused", 16'(p), 16'(pulses));
        check("oe_n", 16'h0000, {15'h0, i_scprb_if.serial_out_line_oe_n});
        $display("test readback done");
        wr(8'h00, 16'h0000);
        wr(8'h16, 16'h0000);
        wr(8'h00, 16'h0002);
        rd(8'h80, 16'hFFFF);
        send(8'h00, 16'h0003);
        check("mode", 16'h0000, {15'h0, readback_mode});
        wr(8'h00, 16'h0002);
        rd(8'h01, 16'h0000);
        rd(8'h81, 16'hFFFF);
        $display("test soft reset done");
        wr(8'h00, 16'h0000);
        wr(8'h02, 16'h00FF);
        wr(8'h00, 16'h0002);
        @(posedge mclk);
        hw_reset_req <= 1'b1;
        repeat (4) @(posedge mclk);
        hw_reset_req <= 1'b0;
        repeat (8) @(negedge mclk);
        check("mode", 16'h0000, {15'h0, readback_mode});
        wr(8'h00, 16'h0002);
        rd(8'h02, 16'h0000);
        $display("test hard reset done");
        close_out();
    end
endmodule : tb
